// >>> crt_pkg.sv
// package for the character recognition test injector
package crt_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned IMG_WORDS = 30;
  localparam int unsigned COL_WORDS = 4;
  localparam int unsigned WORD_W = 14;
  localparam int unsigned COL_BITS = 56;
  localparam int unsigned MAX_IMGS = 8;
  localparam int unsigned IMG_IDX_W = 3;
  localparam int unsigned MEM_DEPTH = 240;
  localparam int unsigned MEM_AW = 8;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned VOLT_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam logic [2:0] OUT_CHANNEL = 3'h7;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  // columns sent per image before it sits centred
  localparam logic [3:0] CENTER_COLS = 4'h7;
  // extra space columns allowed while waiting for data ready
  localparam logic [7:0] MAX_SPACE_COLS = 8'h40;
  localparam logic [WORD_W-1:0] SPACE_WORD = 14'h0000;

  // ----------------------------------------
  // report kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    CRT_RPT_READ, CRT_RPT_MISREAD, CRT_RPT_REJECT, CRT_RPT_REF, CRT_RPT_ERR, CRT_RPT_VOLT
  } crt_rpt_t;

  typedef struct packed {
    logic [2:0] channel;
    logic [WORD_W-1:0] word;
    logic last;
  } crt_chan_t;

  typedef struct packed {
    crt_rpt_t kind;
    logic [CNT_W-1:0] value;
  } crt_host_msg_t;

  typedef struct packed {
    logic [1:0] err_id;
    logic [CODE_W-1:0] expected;
    logic [CODE_W-1:0] received;
  } crt_console_t;

  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_MISREAD = 2'h1;
  localparam logic [1:0] ERR_REJECT = 2'h2;
endpackage

// >>> crt_injector.sv
// character recognition test injector top module
`timescale 1ns/10ps
`default_nettype none

module crt_injector
  import crt_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // image and reference loading
  input wire logic i_img_we,
  input wire logic [MEM_AW-1:0] i_img_addr,
  input wire logic [WORD_W-1:0] i_img_data,
  input wire logic i_ref_we,
  input wire logic [IMG_IDX_W-1:0] i_ref_idx,
  input wire logic [CODE_W-1:0] i_ref_code,
  input wire logic [IMG_IDX_W-1:0] i_last_img,
  // test control
  input wire logic i_start,
  input wire logic i_online,
  input wire logic i_stop_on_error_switch,
  input wire logic i_continue,
  input wire logic [CNT_W-1:0] i_pass_limit,
  // reader side
  input wire logic i_data_ready,
  input wire logic i_reader_error,
  input wire logic i_reject,
  input wire logic [CODE_W-1:0] i_enc_code,
  input wire logic [VOLT_W-1:0] i_char_volt,
  // outputs
  output logic o_chan_valid,
  output crt_chan_t o_chan,
  output logic o_host_valid,
  output crt_host_msg_t o_host_msg,
  output logic o_halted,
  output crt_console_t o_console,
  output logic o_done,
  output logic [CNT_W-1:0] o_read_total,
  output logic [CNT_W-1:0] o_misread_total,
  output logic [CNT_W-1:0] o_reject_total
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEND, ST_WAIT, ST_COMPARE, ST_REPORT, ST_HALT, ST_DONE
  } crt_state_t;

  logic [WORD_W-1:0] img_mem_q [MEM_DEPTH];
  logic [CODE_W-1:0] ref_q [MAX_IMGS];
  logic [CODE_W-1:0] got_q [MAX_IMGS];
  logic [MAX_IMGS-1:0] rej_q;
  logic [VOLT_W-1:0] volt_q [MAX_IMGS];

  crt_state_t state_q;
  logic online_q;
  logic [IMG_IDX_W-1:0] img_q;
  logic [4:0] word_q;
  logic [1:0] sub_q;
  logic [3:0] col_q;
  logic [7:0] space_q;
  logic [2:0] rpt_q;
  logic pass_err_q;
  logic [CNT_W-1:0] pass_q;

  // load stored images one word per write
  genvar gi;
  generate
    for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
      always_ff @(posedge i_core_clk) begin
        if (i_img_we && state_q == ST_IDLE && i_img_addr == MEM_AW'(gi)) begin
          img_mem_q[gi] <= i_img_data;
        end
      end
    end
    for (gi = 0; gi < MAX_IMGS; gi++) begin : g_ref
      always_ff @(posedge i_core_clk) begin
        if (i_ref_we && i_ref_idx == IMG_IDX_W'(gi)) begin
          ref_q[gi] <= i_ref_code;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [MEM_AW-1:0] img_base = MEM_AW'(img_q) * MEM_AW'(IMG_WORDS);
  wire [MEM_AW-1:0] rd_addr = img_base + MEM_AW'(word_q);
  wire col_end = (sub_q == 2'h3);
  wire in_image = (word_q < 5'(IMG_WORDS));
  wire [WORD_W-1:0] out_word = in_image ? img_mem_q[rd_addr] : SPACE_WORD;
  wire centred = (col_q >= CENTER_COLS);
  wire last_img = (img_q == i_last_img);
  wire mismatch = (got_q[img_q] != ref_q[img_q]);
  wire img_rej = rej_q[img_q];
  wire img_err = mismatch || img_rej;
  wire [CNT_W-1:0] imgs_sent = CNT_W'(i_last_img) + 16'h0001;
  wire test_end = (pass_q + 16'h0001 >= i_pass_limit);
  wire pass_done = (pass_q >= i_pass_limit);
  crt_state_t err_next;
  assign err_next = online_q ? ST_REPORT :
                    (i_stop_on_error_switch ? ST_HALT : (test_end ? ST_DONE : ST_SEND));
  wire [1:0] err_id = img_rej ? ERR_REJECT : ERR_MISREAD;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      online_q <= 1'b0;
      img_q <= '0;
      word_q <= '0;
      sub_q <= '0;
      col_q <= '0;
      space_q <= '0;
      rpt_q <= '0;
      pass_err_q <= 1'b0;
      pass_q <= CNT_RESET;
      rej_q <= '0;
      o_chan_valid <= 1'b0;
      o_chan <= '0;
      o_host_valid <= 1'b0;
      o_host_msg <= '0;
      o_halted <= 1'b0;
      o_console <= '0;
      o_done <= 1'b0;
      o_read_total <= CNT_RESET;
      o_misread_total <= CNT_RESET;
      o_reject_total <= CNT_RESET;
    end else begin
      o_chan_valid <= 1'b0;
      o_host_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            online_q <= i_online;
            img_q <= '0;
            word_q <= '0;
            sub_q <= '0;
            col_q <= '0;
            pass_q <= CNT_RESET;
            o_done <= 1'b0;
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          // one 14-bit word per cycle, four per column
          o_chan_valid <= 1'b1;
          o_chan <= '{channel: OUT_CHANNEL, word: out_word, last: col_end};
          sub_q <= sub_q + 2'h1;
          word_q <= in_image ? word_q + 5'h01 : word_q;
          if (col_end) begin
            col_q <= centred ? col_q : col_q + 4'h1;
            if (centred) begin
              state_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (i_data_ready || i_reader_error || space_q == MAX_SPACE_COLS) begin
            got_q[img_q] <= i_enc_code;
            volt_q[img_q] <= i_char_volt;
            rej_q[img_q] <= i_reject || i_reader_error || !i_data_ready;
            space_q <= '0;
            word_q <= '0;
            col_q <= '0;
            if (last_img) begin
              img_q <= '0;
              state_q <= ST_COMPARE;
            end else begin
              img_q <= img_q + IMG_IDX_W'(1);
              state_q <= ST_SEND;
            end
          end else begin
            space_q <= space_q + 8'h01;
            state_q <= ST_SEND;
          end
        end
        ST_COMPARE: begin
          if (img_err) begin
            pass_err_q <= 1'b1;
            o_console <= '{err_id: err_id, expected: ref_q[img_q], received: got_q[img_q]};
            if (img_rej) begin
              o_reject_total <= o_reject_total + 16'h0001;
            end else begin
              o_misread_total <= o_misread_total + 16'h0001;
            end
          end
          if (last_img) begin
            o_read_total <= o_read_total + imgs_sent;
            img_q <= '0;
            rpt_q <= '0;
            if (pass_err_q || img_err) begin
              state_q <= err_next;
              pass_err_q <= 1'b0;
              pass_q <= pass_q + 16'h0001;
            end else if (test_end) begin
              state_q <= ST_DONE;
            end else begin
              pass_q <= pass_q + 16'h0001;
              state_q <= ST_SEND;
            end
          end else begin
            img_q <= img_q + IMG_IDX_W'(1);
          end
        end
        ST_REPORT: begin
          o_host_valid <= 1'b1;
          case (rpt_q)
            3'h0: o_host_msg <= '{kind: CRT_RPT_READ, value: o_read_total};
            3'h1: o_host_msg <= '{kind: CRT_RPT_MISREAD, value: o_misread_total};
            3'h2: o_host_msg <= '{kind: CRT_RPT_REJECT, value: o_reject_total};
            3'h3: o_host_msg <= '{kind: CRT_RPT_REF, value: CNT_W'(ref_q[img_q])};
            3'h4: o_host_msg <= '{kind: CRT_RPT_ERR, value: CNT_W'(got_q[img_q])};
            default: o_host_msg <= '{kind: CRT_RPT_VOLT, value: CNT_W'(volt_q[img_q])};
          endcase
          if (rpt_q == 3'h5) begin
            rpt_q <= '0;
            if (last_img) begin
              img_q <= '0;
              state_q <= pass_done ? ST_DONE : ST_SEND;
            end else begin
              img_q <= img_q + IMG_IDX_W'(1);
            end
          end else begin
            rpt_q <= rpt_q + 3'h1;
          end
        end
        ST_HALT: begin
          o_halted <= 1'b1;
          if (i_continue) begin
            o_halted <= 1'b0;
            state_q <= pass_done ? ST_DONE : ST_SEND;
          end
        end
        ST_DONE: begin
          o_done <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> crt_injector_sva.sv
// port checker for the test injector
`timescale 1ns/10ps
`default_nettype none
module crt_injector_sva import crt_pkg::*; (
  // clock, reset, control
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_stop_on_error_switch,
  // watched outputs
  input wire logic o_chan_valid,
  input wire crt_chan_t o_chan,
  input wire logic o_halted,
  input wire crt_console_t o_console,
  input wire logic o_done,
  input wire logic [CNT_W-1:0] o_read_total,
  input wire logic [CNT_W-1:0] o_misread_total,
  input wire logic [CNT_W-1:0] o_reject_total
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ----
  // column shape, counters, halt and done
  // ----
  sequence s_col;
    (o_chan_valid && !o_chan.last) [*3] ##1 (o_chan_valid && o_chan.last);
  endsequence
  col_shape_a: assert property ($rose(o_chan_valid) |-> s_col) else $error("bad column");
  last_prior_a: assert property (o_chan_valid && o_chan.last |-> $past(o_chan_valid, 3)) else $error("short column");
  chan_id_a: assert property (o_chan_valid |-> o_chan.channel == 3'h7) else $error("wrong channel");
  rst_clear_a: assert property ($rose(i_rst_n) |-> o_read_total == 16'h0000 && o_misread_total == 16'h0000
    && o_reject_total == 16'h0000) else $error("counters not cleared");
  count_up_a: assert property (o_read_total >= $past(o_read_total) && o_misread_total >= $past(o_misread_total)
    && o_reject_total >= $past(o_reject_total)) else $error("counter fell");
  halt_switch_a: assert property ($rose(o_halted) |-> i_stop_on_error_switch) else $error("halt without switch");
  halt_show_a: assert property (o_halted |-> o_console.err_id != ERR_NONE && !o_chan_valid) else $error("bad halt");
  done_quiet_a: assert property (o_done |-> !o_chan_valid) else $error("output after done");
endmodule
bind crt_injector crt_injector_sva u_sva (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_stop_on_error_switch(i_stop_on_error_switch), .o_chan_valid(o_chan_valid), .o_chan(o_chan),
  .o_halted(o_halted), .o_console(o_console), .o_done(o_done), .o_read_total(o_read_total),
  .o_misread_total(o_misread_total), .o_reject_total(o_reject_total));
`default_nettype wire

// >>> crt_reader_model.sv
// reader recognition model fed by injected columns
`timescale 1ns/10ps
`default_nettype none
module crt_reader_model import crt_pkg::*; (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // injected columns and answer setup
  input wire logic i_chan_valid,
  input wire crt_chan_t i_chan,
  input wire logic [CODE_W-1:0] i_code,
  input wire logic i_rej,
  input wire logic [7:0] i_need,
  // answers
  output logic o_data_ready,
  output logic o_reject,
  output logic [CODE_W-1:0] o_enc_code,
  output logic [VOLT_W-1:0] o_char_volt
);
  logic [7:0] cols_q;
  logic hit;
  // ready answers while the last word of the i_need-th column since the previous answer stands
  assign hit = i_chan_valid && i_chan.last && (cols_q + 8'h01 >= i_need);
  // code lines show inverse data while not ready
  assign o_data_ready = hit;
  assign o_reject = hit & i_rej;
  assign o_enc_code = hit ? i_code : ~i_code;
  assign o_char_volt = hit ? {1'b0, i_code} : 8'hff;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cols_q <= 8'h00;
    end else if (hit) begin
      cols_q <= 8'h00;
    end else if (i_chan_valid && i_chan.last) begin
      cols_q <= cols_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> test_crt_injector.sv
// self-checking bench for the test injector
`timescale 1ns/10ps
`default_nettype none
module test_crt_injector import crt_pkg::*;;
  logic clk, rst_n, img_we, ref_we, start, online, sw, cont, dr, rej, chv, hv, halted, done, sawh;
  logic [MEM_AW-1:0] img_addr;
  logic [WORD_W-1:0] img_data;
  logic [IMG_IDX_W-1:0] ref_idx;
  logic [CODE_W-1:0] ref_code, enc, hc;
  logic [VOLT_W-1:0] volt;
  logic [CNT_W-1:0] lim, rd_t, mis_t, rej_t;
  logic [7:0] need;
  logic [2:0] bad, rbad;
  crt_chan_t ch;
  crt_host_msg_t hm;
  crt_console_t con, exp_con;
  logic [WORD_W-1:0] mem [0:89];
  logic [CODE_W-1:0] rtab [0:2];
  int failures, tests_run, idx, img, hn, seed, hi, hexp;
  crt_injector dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_img_we(img_we), .i_img_addr(img_addr),
    .i_img_data(img_data), .i_ref_we(ref_we), .i_ref_idx(ref_idx), .i_ref_code(ref_code), .i_last_img(3'h2),
    .i_start(start), .i_online(online), .i_stop_on_error_switch(sw), .i_continue(cont), .i_pass_limit(lim),
    .i_data_ready(dr), .i_reader_error(1'b0), .i_reject(rej), .i_enc_code(enc), .i_char_volt(volt),
    .o_chan_valid(chv), .o_chan(ch), .o_host_valid(hv), .o_host_msg(hm), .o_halted(halted), .o_console(con),
    .o_done(done), .o_read_total(rd_t), .o_misread_total(mis_t), .o_reject_total(rej_t));
  crt_reader_model rdr (.i_core_clk(clk), .i_rst_n(rst_n), .i_chan_valid(chv), .i_chan(ch),
    .i_code(rtab[img[1:0]] ^ {6'h00, bad[img[1:0]]}), .i_rej(rbad[img[1:0]]), .i_need(need),
    .o_data_ready(dr), .o_reject(rej), .o_enc_code(enc), .o_char_volt(volt));
  // ----
  // checking and ending
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rst_n && chv) begin
      chk(ch.channel, 3'h7);
      chk(ch.word, idx < 30 ? mem[img * 30 + idx] : 14'h0000);
      chk(ch.last, idx % 4 == 3);
      idx++;
      if (dr) begin
        idx = 0;
        img <= (img + 1) % 3;
      end
    end
    if (rst_n && hv) begin
      chk(hm.kind, hn % 6);
      hi = (hn / 6) % 3;
      hc = rtab[hi] ^ {6'h00, bad[hi]};
      case (hn % 6)
        0: hexp = (hn / 18 + 1) * 3;
        1: hexp = (hn / 18 + 1) * $countones(bad & ~rbad);
        2: hexp = (hn / 18 + 1) * $countones(rbad);
        3: hexp = rtab[hi];
        4: hexp = hc;
        default: hexp = {1'b0, hc};
      endcase
      chk(hm.value, hexp);
      hn++;
    end
  end
  // ----
  // one test run
  // ----
  task automatic run(input logic onl, input logic s, input logic [2:0] b, input logic [2:0] r,
                     input logic [7:0] nd, input int passes);
    int k, nerr;
    rst_n = 0;
    online = onl;
    sw = s;
    bad = b;
    rbad = r;
    need = nd;
    lim = passes[15:0];
    sawh = 0;
    repeat (4) @(negedge clk);
    rst_n = 1;
    idx = 0;
    img = 0;
    hn = 0;
    nerr = 0;
    for (k = 0; k < 90; k++) begin
      mem[k] = 14'($random(seed));
      img_we = 1;
      img_addr = k[7:0];
      img_data = mem[k];
      @(negedge clk);
    end
    img_we = 0;
    for (k = 0; k < 3; k++) begin
      rtab[k] = 7'($random(seed));
      ref_we = 1;
      ref_idx = k[2:0];
      ref_code = rtab[k];
      @(negedge clk);
      if (b[k] | r[k]) begin
        nerr++;
        exp_con = {r[k] ? ERR_REJECT : ERR_MISREAD, rtab[k], rtab[k] ^ {6'h00, b[k]}};
      end
    end
    ref_we = 0;
    start = 1;
    @(negedge clk);
    start = 0;
    for (k = 0; k < 20000 && !done; k++) begin
      cont = halted;
      if (halted && !sawh)
        chk(con, exp_con);
      sawh = sawh | halted;
      @(negedge clk);
    end
    cont = 0;
    chk(done, 1);
    chk(rd_t, passes * 3);
    chk(mis_t, passes * $countones(b & ~r));
    chk(rej_t, passes * $countones(r));
    chk(hn > 0, onl && nerr > 0);
    chk(sawh, !onl && s && nerr > 0);
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    wrap_up;
  end
  initial begin
    seed = 32'h6de3;
    {img_we, ref_we, start, cont, img_addr, img_data, ref_idx, ref_code} = '0;
    run(1, 0, 3'b000, 3'b000, 8'h08, 3);
    run(0, 1, 3'b010, 3'b000, 8'h0b, 1);
    run(1, 0, 3'b100, 3'b001, 8'h08, 1);
    run(0, 0, 3'b001, 3'b000, 8'h09, 1);
    wrap_up;
  end
endmodule
`default_nettype wire
